// ===== src/drac_pkg.sv
// Shared constants for the display RAM access control block.
// Assumes a single 25 MHz clock domain and a synchronous active high reset.
package drac_pkg;
	// =====================================================================
	// Geometry of the graphics RAM
	localparam int ROW_WORDS = 132;
	localparam int ROW_COUNT = 176;
	localparam int RAM_WORDS = ROW_WORDS * ROW_COUNT;
	localparam int ROW_BITS = 396;
	localparam logic [7:0] LAST_COL = 8'h83;
	localparam logic [7:0] LAST_ROW = 8'haf;
	// =====================================================================
	// Control register indexes handled inside this block
	localparam logic [5:0] IDX_DRV_OUT = 6'h01;
	localparam logic [5:0] IDX_ENTRY = 6'h03;
	localparam logic [5:0] IDX_CMP_LO = 6'h0a;
	localparam logic [5:0] IDX_MASK = 6'h0b;
	localparam logic [5:0] IDX_POWER = 6'h10;
	localparam logic [5:0] IDX_ADDR_SET = 6'h21;
	localparam logic [5:0] IDX_GRAPHICS_RAM = 6'h22;
	localparam logic [5:0] IDX_WIN_H = 6'h44;
	localparam logic [5:0] IDX_WIN_V = 6'h45;
	// Field positions
	localparam int SS_BIT = 8;
	localparam int ID_BIT = 4;
	localparam int DITH_BIT = 12;
	localparam int OP_LSB = 0;
	localparam int STB_BIT = 0;
	// Reset values
	localparam logic [15:0] WIN_H_RST = 16'h8300;
	localparam logic [15:0] WIN_V_RST = 16'haf00;
	localparam logic [15:0] ENTRY_RST = 16'h0010;
	// Logic operation codes
	typedef enum logic [1:0] {
		DRAC_OP_REPLACE,
		DRAC_OP_OR,
		DRAC_OP_AND,
		DRAC_OP_EQ_SKIP
	} drac_op_t;
endpackage

// ===== src/drac_skid.sv
// Two-entry buffer between the host write path and the RAM write port.
// Assumes valid and ready handshake on both sides, one clock.
module drac_skid (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [31:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [31:0] o_data
);
	logic [31:0] mem [2];
	logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
	logic [1:0] cnt, next_cnt;
	logic push, pop;

	// =====================================================================
	// Pointer and occupancy update.
	always_comb begin
		push = i_valid && (cnt != 2'h2);
		pop = (cnt != 2'h0) && i_ready;
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_cnt = cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			cnt <= 2'h0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			cnt <= next_cnt;
		end
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	assign o_ready = (cnt != 2'h2);
	assign o_valid = (cnt != 2'h0);
	assign o_data = mem[rd_ptr];
endmodule

// ===== src/drac_top.sv
// Host instruction decode and graphics RAM access for a TFT driver.
// Assumes host bus strobes are synchronous to i_clk_sys, one per access.
// Functional notes
// - Address-set write loads the address counter.
// - Each pixel write steps counter up or down.
// - RAM reads never move the address counter.
// - Writes outside the window are dropped.
// - Dithering converts 18-bit pixel to 16-bit.
// - RAM is 132 by 176 sixteen-bit words.
// - Low address byte is column, high is row.
// - Row latched only after all 396 bits.
// - Source shift setting reverses row bit order.
// - Write mask updates only selected bits.
// - Data combined with compare register before writing.
// - Decode uses select, read/write, instruction word.
// - Back-to-back accesses accepted; RAM data writes are dropped while the buffer is full, with o_ready low.
// - Index holds six-bit register number.
// - Status gives raster row in upper byte.
// - Narrow interfaces send two transfers per word.
// - Internal oscillator halts in standby unless external clock is selected.
// - Select and direction choose index, status, data.
// - First RAM read after setup is dummy.
// - Setting zero runs first output to 396.
module drac_top (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_strobe,
	input wire logic i_register_select,
	input wire logic i_read,
	input wire logic i_narrow,
	input wire logic [17:0] i_instruction_bits,
	output logic [15:0] o_rdata,
	output logic o_ready,
	input wire logic [7:0] i_raster_row_position,
	input wire logic i_row_req,
	input wire logic i_ext_clk_sel,
	output logic o_osc_run,
	output logic o_row_valid,
	output logic [395:0] o_source_row
);
	logic [15:0] graphics_ram [drac_pkg::RAM_WORDS];
	logic [5:0] register_index, next_register_index;
	logic [15:0] address_counter, next_address_counter;
	logic [15:0] drv_out, entry, cmp, mask, win_h, win_v, power;
	logic [15:0] next_drv_out, next_entry, next_cmp, next_mask;
	logic [15:0] next_win_h, next_win_v, next_power;
	logic [15:0] read_data_holding, next_read_data_holding;
	logic [15:0] rdata, next_rdata;
	logic rd_primed, next_rd_primed;
	logic [7:0] half_byte, next_half_byte;
	logic half_pend, next_half_pend;
	logic acc_en;
	logic [17:0] acc_word;
	logic wr_idx, rd_stat, wr_data, rd_graphics_ram;
	logic [15:0] pix16, wdat;
	logic in_win;
	logic b_valid, b_ready, b_out_valid;
	logic [31:0] b_in, b_out;

	// Row gatherer.
	typedef enum logic [1:0] {DRAC_IDLE, DRAC_GATHER, DRAC_LATCH} drac_row_t;
	drac_row_t row_st, next_row_st;
	logic [7:0] row_col, next_row_col;
	logic [7:0] row_sel, next_row_sel;
	logic [395:0] row_shift, next_row_shift;
	logic [395:0] row_out, next_row_out;
	logic row_valid, next_row_valid;

	// Converts an 18-bit pixel to 16 bits by dropping the red and blue LSBs.
	function automatic logic [15:0] dither(input logic [17:0] p);
		dither = {p[17:13], p[11:6], p[5:1]};
	endfunction

	// Flat RAM index from a row and column address.
	function automatic int unsigned ram_idx(input logic [15:0] a);
		ram_idx = 32'(a[15:8]) * drac_pkg::ROW_WORDS + 32'(a[7:0]);
	endfunction

	// =====================================================================
	// Byte pairing and access decode.
	always_comb begin
		acc_en = i_strobe && (!i_narrow || half_pend);
		acc_word = i_narrow ? {2'b00, half_byte, i_instruction_bits[17:10]}
			: i_instruction_bits;
		next_half_pend = half_pend;
		next_half_byte = half_byte;
		if (i_strobe && i_narrow) begin
			next_half_pend = !half_pend;
			next_half_byte = i_instruction_bits[17:10];
		end
		wr_idx = acc_en && !i_register_select && !i_read;
		rd_stat = acc_en && !i_register_select && i_read;
		wr_data = acc_en && i_register_select && !i_read;
		rd_graphics_ram = acc_en && i_register_select && i_read;
	end

	// =====================================================================
	// Data path into the buffer: dithering, window check and logic operation.
	always_comb begin
		pix16 = entry[drac_pkg::DITH_BIT] ? dither(acc_word)
			: acc_word[15:0];
		case (drac_pkg::drac_op_t'(entry[drac_pkg::OP_LSB +: 2]))
			drac_pkg::DRAC_OP_OR: wdat = pix16 | cmp;
			drac_pkg::DRAC_OP_AND: wdat = pix16 & cmp;
			default: wdat = pix16;
		endcase
		in_win = (address_counter[7:0] >= win_h[7:0])
			&& (address_counter[7:0] <= win_h[15:8])
			&& (address_counter[15:8] >= win_v[7:0])
			&& (address_counter[15:8] <= win_v[15:8]);
		b_valid = wr_data && register_index == drac_pkg::IDX_GRAPHICS_RAM
			&& in_win && !(entry[drac_pkg::OP_LSB +: 2]
			== 2'(drac_pkg::DRAC_OP_EQ_SKIP) && pix16 == cmp);
		b_in = {address_counter, wdat};
	end

	// =====================================================================
	// Register file and address counter next values.
	always_comb begin
		next_register_index = register_index;
		next_address_counter = address_counter;
		next_drv_out = drv_out;
		next_entry = entry;
		next_cmp = cmp;
		next_mask = mask;
		next_win_h = win_h;
		next_win_v = win_v;
		next_power = power;
		next_rd_primed = rd_primed;
		next_read_data_holding = read_data_holding;
		next_rdata = rdata;
		if (wr_idx) begin
			next_register_index = acc_word[5:0];
			next_rd_primed = 1'b0;
		end
		if (wr_data) begin
			case (register_index)
				drac_pkg::IDX_DRV_OUT: next_drv_out = acc_word[15:0];
				drac_pkg::IDX_ENTRY: next_entry = acc_word[15:0];
				drac_pkg::IDX_CMP_LO: next_cmp = acc_word[15:0];
				drac_pkg::IDX_MASK: next_mask = acc_word[15:0];
				drac_pkg::IDX_WIN_H: next_win_h = acc_word[15:0];
				drac_pkg::IDX_WIN_V: next_win_v = acc_word[15:0];
				drac_pkg::IDX_POWER: next_power = acc_word[15:0];
				drac_pkg::IDX_ADDR_SET: begin
					next_address_counter = acc_word[15:0];
					next_rd_primed = 1'b0;
				end
				drac_pkg::IDX_GRAPHICS_RAM: begin
					// Step regardless of window so the scan still moves.
					if (entry[drac_pkg::ID_BIT]) begin
						next_address_counter = address_counter + 16'h0001;
					end else begin
						next_address_counter = address_counter - 16'h0001;
					end
				end
				default: ;
			endcase
		end
		if (rd_stat) begin
			next_rdata = {i_raster_row_position, 8'h00};
		end
		if (rd_graphics_ram) begin
			// Output previous holding value; first one is a dummy.
			next_rdata = rd_primed ? read_data_holding : 16'h0000;
			next_read_data_holding = graphics_ram[ram_idx(address_counter)];
			next_rd_primed = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			register_index <= 6'h00;
			address_counter <= 16'h0000;
			drv_out <= 16'h0000;
			entry <= drac_pkg::ENTRY_RST;
			cmp <= 16'h0000;
			mask <= 16'h0000;
			win_h <= drac_pkg::WIN_H_RST;
			win_v <= drac_pkg::WIN_V_RST;
			power <= 16'h0000;
			rd_primed <= 1'b0;
			read_data_holding <= 16'h0000;
			rdata <= 16'h0000;
			half_pend <= 1'b0;
			half_byte <= 8'h00;
		end else begin
			register_index <= next_register_index;
			address_counter <= next_address_counter;
			drv_out <= next_drv_out;
			entry <= next_entry;
			cmp <= next_cmp;
			mask <= next_mask;
			win_h <= next_win_h;
			win_v <= next_win_v;
			power <= next_power;
			rd_primed <= next_rd_primed;
			read_data_holding <= next_read_data_holding;
			rdata <= next_rdata;
			half_pend <= next_half_pend;
			half_byte <= next_half_byte;
		end
	end

	// =====================================================================
	// Two-entry buffer toward the RAM write port.
	drac_skid u_skid (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_valid(b_valid),
		.o_ready(b_ready),
		.i_data(b_in),
		.o_valid(b_out_valid),
		.i_ready(row_st != DRAC_GATHER),
		.o_data(b_out)
	);

	// RAM writes drain the buffer whenever the row gatherer is not in DRAC_GATHER.
	always_ff @(posedge i_clk_sys) begin
		if (b_out_valid && row_st != DRAC_GATHER) begin
			graphics_ram[ram_idx(b_out[31:16])] <= (graphics_ram[ram_idx(b_out[31:16])]
				& mask) | (b_out[15:0] & ~mask);
		end
	end

	// =====================================================================
	// Row gatherer: collect 132 words then latch 396 bits.
	always_comb begin
		next_row_st = row_st;
		next_row_col = row_col;
		next_row_sel = row_sel;
		next_row_shift = row_shift;
		next_row_out = row_out;
		next_row_valid = 1'b0;
		case (row_st)
			DRAC_IDLE: begin
				if (i_row_req && !b_out_valid) begin
					next_row_st = DRAC_GATHER;
					next_row_col = 8'h00;
					next_row_sel = i_raster_row_position;
				end
			end
			DRAC_GATHER: begin
				// Three source bits per word: one per colour component.
				next_row_shift = {row_shift[392:0],
					graphics_ram[ram_idx({row_sel, row_col})][15],
					graphics_ram[ram_idx({row_sel, row_col})][10],
					graphics_ram[ram_idx({row_sel, row_col})][4]};
				next_row_col = row_col + 8'h01;
				if (row_col == drac_pkg::LAST_COL) begin
					next_row_st = DRAC_LATCH;
				end
			end
			DRAC_LATCH: begin
				for (int b = 0; b < drac_pkg::ROW_BITS; b++) begin
					next_row_out[b] = drv_out[drac_pkg::SS_BIT]
						? row_shift[b]
						: row_shift[drac_pkg::ROW_BITS - 1 - b];
				end
				next_row_valid = 1'b1;
				next_row_st = DRAC_IDLE;
			end
			default: next_row_st = DRAC_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			row_st <= DRAC_IDLE;
			row_col <= 8'h00;
			row_sel <= 8'h00;
			row_shift <= '0;
			row_out <= '0;
			row_valid <= 1'b0;
		end else begin
			row_st <= next_row_st;
			row_col <= next_row_col;
			row_sel <= next_row_sel;
			row_shift <= next_row_shift;
			row_out <= next_row_out;
			row_valid <= next_row_valid;
		end
	end

	// =====================================================================
	// Outputs.
	assign o_rdata = rdata;
	assign o_ready = b_ready;
	assign o_row_valid = row_valid;
	assign o_source_row = row_out;
	assign o_osc_run = i_ext_clk_sel || !power[drac_pkg::STB_BIT];

	// =====================================================================
	// Checks.
	chk_addr_step: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_data && register_index == drac_pkg::IDX_GRAPHICS_RAM
		&& entry[drac_pkg::ID_BIT] |=> address_counter
		== $past(address_counter) + 16'h0001)
		else $error("address counter did not increment");
	chk_read_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_graphics_ram |=> address_counter == $past(address_counter))
		else $error("read moved address counter");
	chk_addr_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_data && register_index == drac_pkg::IDX_ADDR_SET
		|=> address_counter == $past(acc_word[15:0]))
		else $error("address set not loaded");
	chk_status_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_stat |=> o_rdata[7:0] == 8'h00
		&& o_rdata[15:8] == $past(i_raster_row_position))
		else $error("status read wrong");
	chk_index_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		wr_idx |=> register_index == $past(acc_word[5:0]))
		else $error("index not loaded");
	chk_dummy_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		rd_graphics_ram && !rd_primed |=> o_rdata == 16'h0000)
		else $error("first read not dummy");
	chk_win_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!in_win |-> !b_valid)
		else $error("write outside window");
	chk_row_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_row_valid |-> $past(row_st) == DRAC_LATCH
		&& $past(row_col, 2) == drac_pkg::LAST_COL)
		else $error("row latched early");
endmodule

// ===== verification/drac_host.sv
// Host bus model that issues index, data and read accesses.
// Assumes one access per strobe cycle, synchronous to i_clk_sys.
module drac_host (
	input wire logic i_clk_sys,
	input wire logic i_ready,
	input wire logic [15:0] i_rdata,
	output logic o_strobe,
	output logic o_register_select,
	output logic o_read,
	output logic [17:0] o_instruction_bits
);
	timeunit 1ns;
	timeprecision 100ps;
	// =========================================================
	// Bus idle state
	// Lines start idle with a pattern the block must not use.
	initial begin
		o_strobe = 1'b0;
		o_register_select = 1'b0;
		o_read = 1'b0;
		o_instruction_bits = 18'h2aaaa;
	end
	// =========================================================
	// Access tasks
	// Strobe drops and the bus shows the inverse of its last value.
	task automatic idle(input int n);
		o_strobe = 1'b0;
		o_instruction_bits = ~o_instruction_bits;
		repeat (n) begin
			@(posedge i_clk_sys);
			#1;
		end
	endtask
	// Select and direction code the access kind; strobe stays up.
	task automatic acc(input logic rs, input logic rd, input logic [17:0] d);
		o_register_select = rs;
		o_read = rd;
		o_instruction_bits = d;
		while (rs && !rd && i_ready !== 1'b1) begin
			o_strobe = 1'b0;
			@(posedge i_clk_sys);
			#1;
		end
		o_strobe = 1'b1;
		@(posedge i_clk_sys);
		#1;
	endtask
	// Only implemented indexes are ever selected.
	task automatic reg_wr(input logic [5:0] idx, input logic [15:0] v);
		acc(1'b0, 1'b0, {12'h000, idx});
		acc(1'b1, 1'b0, {2'b00, v});
	endtask
	// The answer is taken one cycle after the read strobe.
	task automatic rd(input logic rs, output logic [15:0] d);
		acc(rs, 1'b1, 18'h00000);
		idle(1);
		d = i_rdata;
	endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the display RAM access block.
// Assumes the host model drives the bus and the bench the side pins.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk_sys, i_rst, i_narrow, i_row_req, i_ext_clk_sel;
	logic [7:0] i_raster_row_position;
	logic strobe, sel, rdn, o_ready, o_osc_run, o_row_valid;
	logic [17:0] bits;
	logic [15:0] o_rdata, v;
	logic [395:0] o_source_row;
	int fails, comparisons, cycles;
	// =========================================================
	// Instances
	drac_host host_u (.i_clk_sys(i_clk_sys), .i_ready(o_ready),
		.i_rdata(o_rdata), .o_strobe(strobe), .o_register_select(sel),
		.o_read(rdn), .o_instruction_bits(bits));
	drac_top dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_strobe(strobe),
		.i_register_select(sel), .i_read(rdn), .i_narrow(i_narrow),
		.i_instruction_bits(bits), .o_rdata(o_rdata), .o_ready(o_ready),
		.i_raster_row_position(i_raster_row_position),
		.i_row_req(i_row_req), .i_ext_clk_sel(i_ext_clk_sel),
		.o_osc_run(o_osc_run), .o_row_valid(o_row_valid),
		.o_source_row(o_source_row));
	// =========================================================
	// Clock, timeout and report
	// The clock toggles every half period of 20 ns.
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	// A hang is cut short well beyond the expected run length.
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			complete_run();
		end
	end
	task automatic check(input logic [395:0] seen, input logic [395:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// =========================================================
	// Helpers
	// Sets the counter and opens a burst of RAM data writes.
	task automatic ram_wr(input logic [15:0] a, input logic [17:0] d);
		host_u.reg_wr(drac_pkg::IDX_ADDR_SET, a);
		host_u.acc(1'b0, 1'b0, {12'h000, drac_pkg::IDX_GRAPHICS_RAM});
		host_u.acc(1'b1, 1'b0, d);
	endtask
	// Lets the buffer drain, then a dummy read and a real read.
	task automatic ram_rd(input logic [15:0] a, output logic [15:0] d);
		host_u.idle(4);
		host_u.reg_wr(drac_pkg::IDX_ADDR_SET, a);
		host_u.acc(1'b0, 1'b0, {12'h000, drac_pkg::IDX_GRAPHICS_RAM});
		host_u.rd(1'b1, d);
		host_u.rd(1'b1, d);
	endtask
	// =========================================================
	// Scenarios
	task automatic t_status();
		for (int r = 1; r < 3; r++) begin
			i_raster_row_position = 8'(r * 8'h55);
			host_u.rd(1'b0, v);
			check(v, {8'(r * 8'h55), 8'h00});
		end
	endtask
	task automatic t_addr();
		ram_wr(16'h0105, 18'h01234);
		host_u.acc(1'b1, 1'b0, 18'h05678);
		host_u.idle(4);
		host_u.reg_wr(drac_pkg::IDX_ADDR_SET, 16'h0105);
		host_u.acc(1'b0, 1'b0, {12'h000, drac_pkg::IDX_GRAPHICS_RAM});
		host_u.rd(1'b1, v);
		check(v, 16'h0000);
		host_u.rd(1'b1, v);
		check(v, 16'h1234);
		host_u.acc(1'b1, 1'b0, 18'h09abc);
		ram_rd(16'h0105, v);
		check(v, 16'h9abc);
		ram_rd(16'h0106, v);
		check(v, 16'h5678);
	endtask
	task automatic t_down();
		host_u.reg_wr(drac_pkg::IDX_ENTRY, 16'h0000);
		ram_wr(16'h0130, 18'h01111);
		host_u.acc(1'b1, 1'b0, 18'h02222);
		ram_rd(16'h012f, v);
		check(v, 16'h2222);
		host_u.reg_wr(drac_pkg::IDX_ENTRY, drac_pkg::ENTRY_RST);
	endtask
	task automatic t_window();
		ram_wr(16'h0003, 18'h0aaaa);
		host_u.idle(4);
		host_u.reg_wr(drac_pkg::IDX_WIN_H, 16'h0504);
		ram_wr(16'h0003, 18'h0bbbb);
		host_u.acc(1'b1, 1'b0, 18'h0cccc);
		ram_rd(16'h0003, v);
		check(v, 16'haaaa);
		ram_rd(16'h0004, v);
		check(v, 16'hcccc);
		host_u.reg_wr(drac_pkg::IDX_WIN_V, 16'haf01);
		ram_wr(16'h0004, 18'h0dddd);
		ram_rd(16'h0004, v);
		check(v, 16'hcccc);
		host_u.reg_wr(drac_pkg::IDX_WIN_V, drac_pkg::WIN_V_RST);
		host_u.reg_wr(drac_pkg::IDX_WIN_H, drac_pkg::WIN_H_RST);
	endtask
	task automatic t_mask();
		ram_wr(16'h0020, 18'h01111);
		host_u.idle(4);
		host_u.reg_wr(drac_pkg::IDX_MASK, 16'h00ff);
		ram_wr(16'h0020, 18'h02222);
		ram_rd(16'h0020, v);
		check(v, 16'h2211);
		host_u.reg_wr(drac_pkg::IDX_MASK, 16'h0000);
	endtask
	// Every operation code against compare value 0x0ff0.
	task automatic t_ops();
		logic [15:0] exp [4] = '{16'h3c3c, 16'h3ffc, 16'h0c30, 16'h5555};
		host_u.reg_wr(drac_pkg::IDX_CMP_LO, 16'h0ff0);
		for (int op = 0; op < 4; op++) begin
			host_u.reg_wr(drac_pkg::IDX_ENTRY, 16'h0010);
			ram_wr(16'h0040, 18'h05555);
			host_u.idle(4);
			host_u.reg_wr(drac_pkg::IDX_ENTRY, 16'h0010 | 16'(op));
			ram_wr(16'h0040, (op == 3) ? 18'h00ff0 : 18'h03c3c);
			ram_rd(16'h0040, v);
			check(v, exp[op]);
		end
		host_u.reg_wr(drac_pkg::IDX_ENTRY, 16'h0010);
	endtask
	task automatic t_dither();
		host_u.reg_wr(drac_pkg::IDX_ENTRY, 16'h1010);
		ram_wr(16'h0050, 18'h20820);
		host_u.acc(1'b1, 1'b0, 18'h3ffff);
		ram_rd(16'h0050, v);
		check(v, 16'h8410);
		ram_rd(16'h0051, v);
		check(v, 16'hffff);
		host_u.reg_wr(drac_pkg::IDX_ENTRY, 16'h0010);
	endtask
	// Index, address and data all sent as high byte then low byte.
	task automatic t_narrow();
		logic [7:0] b [8] = '{8'h00, 8'h21, 8'h00, 8'h60,
			8'h00, 8'h22, 8'hbe, 8'hef};
		host_u.idle(1);
		i_narrow = 1'b1;
		for (int i = 0; i < 8; i++)
			host_u.acc(1'(i[1]), 1'b0, {b[i], 10'h000});
		host_u.idle(1);
		i_narrow = 1'b0;
		ram_rd(16'h0060, v);
		check(v, 16'hbeef);
	endtask
	task automatic t_osc();
		host_u.reg_wr(drac_pkg::IDX_POWER, 16'h0001);
		host_u.idle(1);
		check(o_osc_run, 1'b0);
		i_ext_clk_sel = 1'b1;
		host_u.idle(1);
		check(o_osc_run, 1'b1);
		i_ext_clk_sel = 1'b0;
		host_u.reg_wr(drac_pkg::IDX_POWER, 16'h0000);
		host_u.idle(1);
		check(o_osc_run, 1'b1);
	endtask
	// Row 2 holds one lit pixel in column 0; both shift settings.
	task automatic t_row();
		int n;
		logic [15:0] a = 16'h0200;
		ram_wr(a, 18'h08410);
		for (int i = 1; i < 132; i++)
			host_u.acc(1'b1, 1'b0, 18'h00000);
		for (int ss = 0; ss < 2; ss++) begin
			host_u.reg_wr(drac_pkg::IDX_DRV_OUT, ss ? 16'h0100 : 16'h0000);
			host_u.idle(4);
			i_raster_row_position = a[15:8];
			i_row_req = 1'b1;
			@(posedge i_clk_sys);
			#1;
			i_row_req = 1'b0;
			// Writes during the gather fill the buffer and stall.
			host_u.reg_wr(drac_pkg::IDX_ADDR_SET, 16'h0300);
			host_u.acc(1'b0, 1'b0, {12'h000, drac_pkg::IDX_GRAPHICS_RAM});
			host_u.acc(1'b1, 1'b0, 18'h00000);
			host_u.acc(1'b1, 1'b0, 18'h00000);
			host_u.idle(1);
			check(o_ready, 1'b0);
			n = 0;
			while (o_row_valid !== 1'b1 && n < 1000) begin
				@(posedge i_clk_sys);
				#1;
				n++;
			end
			check(o_row_valid, 1'b1);
			check(o_source_row, ss ? {3'b111, 393'h0} : 396'h7);
		end
		host_u.idle(1);
	endtask
	// =========================================================
	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_narrow = 1'b0;
		i_row_req = 1'b0;
		i_ext_clk_sel = 1'b0;
		i_raster_row_position = 8'h00;
		fails = 0;
		comparisons = 0;
		cycles = 0;
		repeat (2) @(posedge i_clk_sys);
		#1;
		i_rst = 1'b0;
		check({o_ready, o_osc_run, o_row_valid, o_rdata}, 19'h60000);
		check(o_source_row, 396'h0);
		host_u.reg_wr(drac_pkg::IDX_MASK, 16'h0000);
		t_status();
		t_addr();
		t_down();
		t_window();
		t_mask();
		t_ops();
		t_dither();
		t_narrow();
		t_osc();
		t_row();
		complete_run();
	end
endmodule
